/* hdl/acc_pkg.sv */
// package for the audio clock control block
// assumes a single 250 MHz system clock and an AXI4-Lite register port
package acc_pkg;

  // ==========================================================
  // register map (index, byte address is four times the index)
  localparam int ADDR_W = 8;
  localparam logic [5:0] IDX_CLOCK_DIVIDER_CONTROL = 6'h0C;
  localparam logic [5:0] IDX_RATE_RATIO_CONTROL = 6'h0D;
  localparam logic [5:0] IDX_CLOCK_SOURCE_ENABLE_CONTROL = 6'h0E;
  localparam logic [5:0] IDX_LOOP_CONTROL = 6'h10;
  localparam logic [5:0] IDX_PORT_CONTROL = 6'h17;
  localparam logic [5:0] IDX_BIT_CLOCK_DIVIDER = 6'h18;
  localparam logic [5:0] IDX_FRAME_RATE = 6'h19;
  localparam logic [5:0] IDX_STATUS = 6'h1F;

  // ==========================================================
  // field positions
  localparam int CD_HALVE_BIT = 7;
  localparam int CD_TOSEL_LSB = 8;
  localparam int CD_OUTDIV_LSB = 10;
  localparam int RR_FS_LSB = 0;
  localparam int RR_RATIO_LSB = 4;
  localparam int SE_CORE_BIT = 0;
  localparam int SE_DAC_BIT = 1;
  localparam int SE_TO_BIT = 2;
  localparam int SE_OUT_BIT = 5;
  localparam int SE_SRC_BIT = 13;
  localparam int LP_HOLD_BIT = 3;
  localparam int LP_REF_LSB = 4;
  localparam int PT_BIT_MST_BIT = 0;
  localparam int PT_FRM_MST_BIT = 1;
  localparam int PT_FRM_EXT_BIT = 2;

  // ==========================================================
  // reset values and writable masks
  localparam logic [15:0] RST_CLOCK_DIVIDER = 16'h0000;
  localparam logic [15:0] RST_RATE_RATIO = 16'h0038;
  localparam logic [15:0] RST_SOURCE_ENABLE = 16'h0000;
  localparam logic [15:0] RST_LOOP = 16'h0000;
  localparam logic [15:0] RST_PORT = 16'h0000;
  localparam logic [15:0] RST_BIT_DIV = 16'h0008;
  localparam logic [15:0] RST_FRAME = 16'h0040;
  localparam logic [15:0] MSK_CLOCK_DIVIDER = 16'h1F80;
  localparam logic [15:0] MSK_RATE_RATIO = 16'h00FF;
  localparam logic [15:0] MSK_SOURCE_ENABLE = 16'h2027;
  localparam logic [15:0] MSK_LOOP = 16'h0038;
  localparam logic [15:0] MSK_PORT = 16'h0007;
  localparam logic [15:0] MSK_BIT_DIV = 16'h001F;
  localparam logic [15:0] MSK_FRAME = 16'h07FF;

  // ==========================================================
  // code limits, rates and responses
  localparam logic [3:0] FS_CODE_MAX = 4'hA;
  localparam logic [3:0] RATIO_CODE_MAX = 4'h9;
  localparam logic [4:0] BIT_CODE_MAX = 5'h14;
  localparam int TO_BASE_HZ = 125;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0]
  {
    ACC_WR_IDLE = 2'b01,
    ACC_WR_RESP = 2'b10
  } acc_wr_state_type;

endpackage : acc_pkg

/* hdl/acc_tick_div.sv */
// fractional tick divider: emits one pulse per limit/step input ticks
// assumes input ticks are one-cycle enables on the system clock
`timescale 1ns/100ps
module acc_tick_div #(
  parameter int W = 24
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_run,
  input wire logic i_tick,
  input wire logic [W-1:0] i_step,
  input wire logic [W-1:0] i_limit,
  output logic o_tick
);
  logic [W-1:0] acc_ff;
  logic [W-1:0] lim_ff;
  logic [W-1:0] nxt_sum;

  assign nxt_sum = acc_ff + i_step;

  // ==========================================================
  // accumulator, new limit taken while stopped or at an output boundary
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      acc_ff <= '0;
      lim_ff <= '0;
      o_tick <= 1'b0;
    end
    else if (!i_run)
    begin
      acc_ff <= '0;
      lim_ff <= i_limit;
      o_tick <= 1'b0;
    end
    else
    begin
      o_tick <= 1'b0;
      if (i_tick && lim_ff != '0)
      begin
        if (nxt_sum >= lim_ff)
        begin
          acc_ff <= nxt_sum - lim_ff;
          lim_ff <= i_limit;
          o_tick <= 1'b1;
        end
        else
        begin
          acc_ff <= nxt_sum;
        end
      end
    end
  end

endmodule : acc_tick_div

/* hdl/acc_clock_control.sv */
// audio system clock control: source select, gating and clock dividers
// assumes all clock inputs are one-cycle tick enables on i_sys_clk
//
// Overview of operation
// RQ1: the core system clock tick is the single reference for all derived clocks; the frame divider can count the external bit clock tick instead.
// RQ2: source select bit 13 picks pin clock (0) or locked loop (1), reset 0.
// RQ3: halve bit 7 passes the source (0) or divides it by two (1).
// RQ4: core clock runs only when gate bit 0 is set; reset leaves it off.
// RQ5: software clears the core gate before changing the source.
// RQ6: software finishes clock setup before playback starts.
// RQ7: ratio field 7:4 codes 64 to 1536 core ticks per sample, reset 0011.
// RQ8: sample rate field 3:0, codes 1011 to 1111 reserved, reset 1000.
// RQ9: sample tick derived automatically from rate and ratio codes.
// RQ10: DAC path clock gated by bit 1, reset off.
// RQ11: slow timeout clock derived from core clock, runs only with bit 2 set.
// RQ12: timeout select bits 9:8 give 125, 250, 500 or 1000 Hz.
// RQ13: clock output drives the pin clock only when bit 5 is set.
// RQ14: output divider bits 12:10 divide by 1,2,3,4,6,8,12,16, reset 000.
// RQ15: software enables clock output only when pin clock is not the source.
// RQ16: frame clock divides an internal or external bit clock in master mode.
// RQ17: locked loop reference selects pin clock, bit clock or frame clock.
// RQ18: locked loop may free-run without a reference when hold is set.
// RQ19: bit clock divider field 4:0 divides core clock by 1 to 48.
// RQ20: frame rate field 10:0 divides the bit clock by that integer.
// RQ21: gates and divider settings change only at clock boundaries; timeout and output gates (bits 2, 5) act on the next system clock.
`timescale 1ns/100ps
module acc_clock_control #(
  parameter int unsigned CORE_CLK_HZ = 12288000
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [acc_pkg::ADDR_W-1:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [acc_pkg::ADDR_W-1:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  input wire logic i_mpin_tick,
  input wire logic i_loop_tick,
  input wire logic i_ext_bclk_tick,
  output logic o_core_tick,
  output logic o_dac_tick,
  output logic o_fs_tick,
  output logic o_timeout_tick,
  output logic o_mpin_out,
  output logic o_mpin_oe_n,
  output logic o_bclk_tick,
  output logic o_frame_tick,
  output logic [1:0] o_loop_ref_sel,
  output logic o_loop_hold
);
  import acc_pkg::*;

  localparam logic [23:0] TO_LIM_BASE = 24'(CORE_CLK_HZ / TO_BASE_HZ);

  // ==========================================================
  // lookup tables
  function automatic logic [23:0] ratio_lim(input logic [3:0] code);
    case (code)
      4'h0: ratio_lim = 24'h000040;
      4'h1: ratio_lim = 24'h000080;
      4'h2: ratio_lim = 24'h0000C0;
      4'h3: ratio_lim = 24'h000100;
      4'h4: ratio_lim = 24'h000180;
      4'h5: ratio_lim = 24'h000200;
      4'h6: ratio_lim = 24'h000300;
      4'h7: ratio_lim = 24'h000400;
      4'h8: ratio_lim = 24'h000580;
      4'h9: ratio_lim = 24'h000600;
      default: ratio_lim = 24'h000000;
    endcase
  endfunction : ratio_lim

  function automatic logic [23:0] outdiv_lim(input logic [2:0] code);
    case (code)
      3'h0: outdiv_lim = 24'h000001;
      3'h1: outdiv_lim = 24'h000002;
      3'h2: outdiv_lim = 24'h000003;
      3'h3: outdiv_lim = 24'h000004;
      3'h4: outdiv_lim = 24'h000006;
      3'h5: outdiv_lim = 24'h000008;
      3'h6: outdiv_lim = 24'h00000C;
      default: outdiv_lim = 24'h000010;
    endcase
  endfunction : outdiv_lim

  // twice the divide ratio, so half steps stay integer
  function automatic logic [23:0] bitdiv_lim2(input logic [4:0] code);
    case (code)
      5'h00: bitdiv_lim2 = 24'h000002;
      5'h01: bitdiv_lim2 = 24'h000003;
      5'h02: bitdiv_lim2 = 24'h000004;
      5'h03: bitdiv_lim2 = 24'h000006;
      5'h04: bitdiv_lim2 = 24'h000008;
      5'h05: bitdiv_lim2 = 24'h00000A;
      5'h06: bitdiv_lim2 = 24'h00000B;
      5'h07: bitdiv_lim2 = 24'h00000C;
      5'h08: bitdiv_lim2 = 24'h000010;
      5'h09: bitdiv_lim2 = 24'h000014;
      5'h0A: bitdiv_lim2 = 24'h000016;
      5'h0B: bitdiv_lim2 = 24'h000018;
      5'h0C: bitdiv_lim2 = 24'h000020;
      5'h0D: bitdiv_lim2 = 24'h000028;
      5'h0E: bitdiv_lim2 = 24'h00002C;
      5'h0F: bitdiv_lim2 = 24'h000030;
      5'h10: bitdiv_lim2 = 24'h000032;
      5'h11: bitdiv_lim2 = 24'h00003C;
      5'h12: bitdiv_lim2 = 24'h000040;
      5'h13: bitdiv_lim2 = 24'h000058;
      5'h14: bitdiv_lim2 = 24'h000060;
      default: bitdiv_lim2 = 24'h000000;
    endcase
  endfunction : bitdiv_lim2

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb, input logic [15:0] msk);
    logic [15:0] val;
    val = old;
    if (strb[0])
      val[7:0] = data[7:0];
    if (strb[1])
      val[15:8] = data[15:8];
    merge16 = val & msk;
  endfunction : merge16

  // ==========================================================
  // registers
  logic [15:0] clock_divider_control_ff;
  logic [15:0] rate_ratio_control_ff;
  logic [15:0] clock_source_enable_control_ff;
  logic [15:0] loop_control_ff;
  logic [15:0] port_control_ff;
  logic [15:0] bit_clock_divider_ff;
  logic [15:0] frame_rate_ff;
  acc_wr_state_type wr_state_ff;
  logic aw_got_ff;
  logic w_got_ff;
  logic [5:0] aw_idx_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic wr_go;
  logic wr_hit;
  logic [15:0] rd_val;
  logic rd_hit;

  // ==========================================================
  // axi4-lite write channel
  assign wr_go = (wr_state_ff == ACC_WR_IDLE) && aw_got_ff && w_got_ff;
  assign wr_hit = (aw_idx_ff == IDX_CLOCK_DIVIDER_CONTROL) || (aw_idx_ff == IDX_RATE_RATIO_CONTROL)
                  || (aw_idx_ff == IDX_CLOCK_SOURCE_ENABLE_CONTROL) || (aw_idx_ff == IDX_LOOP_CONTROL)
                  || (aw_idx_ff == IDX_PORT_CONTROL) || (aw_idx_ff == IDX_BIT_CLOCK_DIVIDER)
                  || (aw_idx_ff == IDX_FRAME_RATE);

  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      aw_idx_ff <= '0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
      o_awready <= 1'b0;
      o_wready <= 1'b0;
    end
    else
    begin
      if (o_awready && i_awvalid)
      begin
        aw_got_ff <= 1'b1;
        aw_idx_ff <= i_awaddr[7:2];
      end
      else if (o_bvalid && i_bready)
        aw_got_ff <= 1'b0;
      if (o_wready && i_wvalid)
      begin
        w_got_ff <= 1'b1;
        wdata_ff <= i_wdata;
        wstrb_ff <= i_wstrb;
      end
      else if (o_bvalid && i_bready)
        w_got_ff <= 1'b0;
      o_awready <= (wr_state_ff == ACC_WR_IDLE) && !aw_got_ff && !(o_awready && i_awvalid);
      o_wready <= (wr_state_ff == ACC_WR_IDLE) && !w_got_ff && !(o_wready && i_wvalid);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      wr_state_ff <= ACC_WR_IDLE;
      o_bvalid <= 1'b0;
      o_bresp <= RESP_OKAY;
    end
    else
    begin
      case (wr_state_ff)
        ACC_WR_IDLE:
          if (wr_go)
          begin
            wr_state_ff <= ACC_WR_RESP;
            o_bvalid <= 1'b1;
            o_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
          end
        ACC_WR_RESP:
          if (i_bready)
          begin
            wr_state_ff <= ACC_WR_IDLE;
            o_bvalid <= 1'b0;
          end
        default:
        begin
          wr_state_ff <= ACC_WR_IDLE;
          o_bvalid <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      clock_divider_control_ff <= RST_CLOCK_DIVIDER;
      rate_ratio_control_ff <= RST_RATE_RATIO;
      clock_source_enable_control_ff <= RST_SOURCE_ENABLE;
      loop_control_ff <= RST_LOOP;
      port_control_ff <= RST_PORT;
      bit_clock_divider_ff <= RST_BIT_DIV;
      frame_rate_ff <= RST_FRAME;
    end
    else if (wr_go)
    begin
      case (aw_idx_ff)
        IDX_CLOCK_DIVIDER_CONTROL: clock_divider_control_ff <=
          merge16(clock_divider_control_ff, wdata_ff, wstrb_ff, MSK_CLOCK_DIVIDER);
        IDX_RATE_RATIO_CONTROL: rate_ratio_control_ff <=
          merge16(rate_ratio_control_ff, wdata_ff, wstrb_ff, MSK_RATE_RATIO);
        IDX_CLOCK_SOURCE_ENABLE_CONTROL: clock_source_enable_control_ff <=
          merge16(clock_source_enable_control_ff, wdata_ff, wstrb_ff, MSK_SOURCE_ENABLE);
        IDX_LOOP_CONTROL: loop_control_ff <=
          merge16(loop_control_ff, wdata_ff, wstrb_ff, MSK_LOOP);
        IDX_PORT_CONTROL: port_control_ff <=
          merge16(port_control_ff, wdata_ff, wstrb_ff, MSK_PORT);
        IDX_BIT_CLOCK_DIVIDER: bit_clock_divider_ff <=
          merge16(bit_clock_divider_ff, wdata_ff, wstrb_ff, MSK_BIT_DIV);
        IDX_FRAME_RATE: frame_rate_ff <=
          merge16(frame_rate_ff, wdata_ff, wstrb_ff, MSK_FRAME);
        default: ;
      endcase
    end
  end

  // ==========================================================
  // field decode
  logic src_sel;
  logic halve;
  logic core_gate;
  logic dac_gate;
  logic to_gate;
  logic out_gate;
  logic [1:0] to_sel;
  logic [2:0] out_div;
  logic [3:0] fs_code;
  logic [3:0] ratio_code;
  logic [4:0] bit_code;
  logic fs_ok;
  logic bit_ok;

  assign src_sel = clock_source_enable_control_ff[SE_SRC_BIT];
  assign core_gate = clock_source_enable_control_ff[SE_CORE_BIT];
  assign dac_gate = clock_source_enable_control_ff[SE_DAC_BIT];
  assign to_gate = clock_source_enable_control_ff[SE_TO_BIT];
  assign out_gate = clock_source_enable_control_ff[SE_OUT_BIT];
  assign halve = clock_divider_control_ff[CD_HALVE_BIT];
  assign to_sel = clock_divider_control_ff[CD_TOSEL_LSB +: 2];
  assign out_div = clock_divider_control_ff[CD_OUTDIV_LSB +: 3];
  assign fs_code = rate_ratio_control_ff[RR_FS_LSB +: 4];
  assign ratio_code = rate_ratio_control_ff[RR_RATIO_LSB +: 4];
  assign bit_code = bit_clock_divider_ff[4:0];
  assign fs_ok = (fs_code <= FS_CODE_MAX) && (ratio_code <= RATIO_CODE_MAX); // see RQ8
  assign bit_ok = bit_code <= BIT_CODE_MAX; // see RQ19

  // ==========================================================
  // core clock source, halving and gating
  logic src_tick;
  logic pass_tick;
  logic half_phase_ff;
  logic core_eff_ff;
  logic dac_eff_ff;

  assign src_tick = src_sel ? i_loop_tick : i_mpin_tick; // see RQ2
  assign pass_tick = src_tick && (!halve || half_phase_ff); // see RQ3

  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      half_phase_ff <= 1'b0;
      core_eff_ff <= 1'b0;
      dac_eff_ff <= 1'b0;
      o_core_tick <= 1'b0;
      o_dac_tick <= 1'b0;
    end
    else
    begin
      if (src_tick)
      begin
        half_phase_ff <= halve ? !half_phase_ff : 1'b0; // see RQ3
        core_eff_ff <= core_gate; // see RQ21
        dac_eff_ff <= core_gate && dac_gate; // see RQ21
      end
      o_core_tick <= pass_tick && core_eff_ff; // see RQ4
      o_dac_tick <= pass_tick && dac_eff_ff; // see RQ10
    end
  end

  // ==========================================================
  // derived clocks, all but the frame divider fed by the core tick
  logic to_run;
  logic out_run;
  logic bit_run;
  logic frame_run;
  logic frame_src_tick;

  assign to_run = to_gate && core_eff_ff; // see RQ11
  assign out_run = out_gate && src_sel && core_eff_ff; // see RQ13
  assign bit_run = port_control_ff[PT_BIT_MST_BIT] && bit_ok && core_eff_ff;
  assign frame_run = port_control_ff[PT_FRM_MST_BIT] && (frame_rate_ff[10:0] != 11'h000);
  assign frame_src_tick = port_control_ff[PT_FRM_EXT_BIT] ? i_ext_bclk_tick : o_bclk_tick; // see RQ16

  acc_tick_div #(.W(24)) u_fs_div ( // see RQ1 RQ9
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_run(fs_ok && core_eff_ff),
    .i_tick(o_core_tick),
    .i_step(24'h000001),
    .i_limit(ratio_lim(ratio_code)), // see RQ7
    .o_tick(o_fs_tick)
  );

  acc_tick_div #(.W(24)) u_to_div ( // see RQ11
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_run(to_run),
    .i_tick(o_core_tick),
    .i_step(24'h000001),
    .i_limit(TO_LIM_BASE >> to_sel), // see RQ12
    .o_tick(o_timeout_tick)
  );

  acc_tick_div #(.W(24)) u_out_div ( // see RQ14
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_run(out_run),
    .i_tick(o_core_tick),
    .i_step(24'h000001),
    .i_limit(outdiv_lim(out_div)),
    .o_tick(o_mpin_out)
  );

  acc_tick_div #(.W(24)) u_bit_div ( // see RQ19
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_run(bit_run),
    .i_tick(o_core_tick),
    .i_step(24'h000002),
    .i_limit(bitdiv_lim2(bit_code)),
    .o_tick(o_bclk_tick)
  );

  acc_tick_div #(.W(24)) u_frame_div ( // see RQ20
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_run(frame_run),
    .i_tick(frame_src_tick),
    .i_step(24'h000001),
    .i_limit({13'h0000, frame_rate_ff[10:0]}),
    .o_tick(o_frame_tick)
  );

  // ==========================================================
  // pin drive and locked loop controls
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_mpin_oe_n <= 1'b1;
      o_loop_ref_sel <= 2'h0;
      o_loop_hold <= 1'b0;
    end
    else
    begin
      o_mpin_oe_n <= !(out_gate && src_sel); // see RQ13 RQ15
      o_loop_ref_sel <= loop_control_ff[LP_REF_LSB +: 2]; // see RQ17
      o_loop_hold <= loop_control_ff[LP_HOLD_BIT]; // see RQ18
    end
  end

  // ==========================================================
  // axi4-lite read channel
  always_comb
  begin
    rd_hit = 1'b1;
    case (i_araddr[7:2])
      IDX_CLOCK_DIVIDER_CONTROL: rd_val = clock_divider_control_ff;
      IDX_RATE_RATIO_CONTROL: rd_val = rate_ratio_control_ff;
      IDX_CLOCK_SOURCE_ENABLE_CONTROL: rd_val = clock_source_enable_control_ff;
      IDX_LOOP_CONTROL: rd_val = loop_control_ff;
      IDX_PORT_CONTROL: rd_val = port_control_ff;
      IDX_BIT_CLOCK_DIVIDER: rd_val = bit_clock_divider_ff;
      IDX_FRAME_RATE: rd_val = frame_rate_ff;
      IDX_STATUS: rd_val = {10'h000, bit_ok, fs_ok, !o_mpin_oe_n, to_run, dac_eff_ff, core_eff_ff};
      default:
      begin
        rd_val = 16'h0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h00000000;
      o_rresp <= RESP_OKAY;
    end
    else if (o_arready && i_arvalid)
    begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b1;
      o_rdata <= {16'h0000, rd_val};
      o_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (o_rvalid)
    begin
      if (i_rready)
        o_rvalid <= 1'b0;
    end
    else
      o_arready <= 1'b1;
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_resetn);

  sequence ext_idle;
    port_control_ff[PT_FRM_EXT_BIT] && !i_ext_bclk_tick;
  endsequence

  core_gate_a: assert property (!core_eff_ff |=> !o_core_tick) // see RQ4
    else $error("core tick while gated");
  src_sel_a: assert property ((!src_sel && !i_mpin_tick) |=> !o_core_tick) // see RQ2
    else $error("core tick without pin source tick");
  halve_pace_a: assert property ((halve && $stable(halve) && o_core_tick) |=> !o_core_tick) // see RQ3
    else $error("halved clock too fast");
  dac_gate_a: assert property (o_dac_tick |-> o_core_tick && $past(dac_gate, 2)) // see RQ10
    else $error("dac tick not tied to core tick");
  timeout_off_a: assert property (!to_run |=> !o_timeout_tick) // see RQ11
    else $error("timeout tick while disabled");
  pin_drive_a: assert property ((out_gate && src_sel) |=> !o_mpin_oe_n) // see RQ13
    else $error("clock output pin not driven");
  fs_reserved_a: assert property (!fs_ok |=> !o_fs_tick) // see RQ8
    else $error("sample tick on reserved code");
  bit_src_a: assert property (o_bclk_tick |-> $past(o_core_tick)) // see RQ19
    else $error("bit tick without core tick");
  frame_src_a: assert property (o_frame_tick |-> $past(frame_run) && $past(frame_src_tick)) // see RQ20
    else $error("frame tick without bit tick");
  frame_step_a: assert property (ext_idle |=> !o_frame_tick) // see RQ16
    else $error("frame tick without external bit tick");
  bresp_hold_a: assert property ((o_bvalid && !i_bready) |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped");

endmodule : acc_clock_control

/* sim/acc_clock_control_tb.sv */
// bench for the audio clock control block
// assumes acc_pkg and acc_clock_control, ticks modelled as enables
`timescale 1ns/100ps
module acc_clock_control_tb;
  import acc_pkg::*;
  logic clk = 0, rstn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, mp = 0, lp = 0, eb = 0;
  logic [ADDR_W-1:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, d, rdat;
  logic [1:0] r, bresp, rresp, lr;
  logic awr, wrdy, bv, arr, rv, core, dac, fs, to, mo, oe, bc, fr, lh;
  int n_fail = 0, tests_run = 0, seed = 12, cyc = 0;
  int rt[3] = '{64, 128, 192};
  int od[8] = '{1, 2, 3, 4, 6, 8, 12, 16};
  wire [6:0] sig = {fr, bc, mo, to, fs, dac, core};
  // ==========================================================
  // device and clock
  acc_clock_control #(.CORE_CLK_HZ(1000)) acc_clock_control_i (.i_sys_clk(clk),
    .i_resetn(rstn), .i_awvalid(awv), .o_awready(awr), .i_awaddr(awa), .i_wvalid(wv),
    .o_wready(wrdy), .i_wdata(wd), .i_wstrb(4'hF), .o_bvalid(bv), .i_bready(br),
    .o_bresp(bresp), .i_arvalid(arv), .o_arready(arr), .i_araddr(ara), .o_rvalid(rv),
    .i_rready(rr), .o_rdata(rdat), .o_rresp(rresp), .i_mpin_tick(mp), .i_loop_tick(lp),
    .i_ext_bclk_tick(eb), .o_core_tick(core), .o_dac_tick(dac), .o_fs_tick(fs),
    .o_timeout_tick(to), .o_mpin_out(mo), .o_mpin_oe_n(oe), .o_bclk_tick(bc),
    .o_frame_tick(fr), .o_loop_ref_sel(lr), .o_loop_hold(lh));
  initial forever #2 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      n_fail++;
      conclude();
    end
  end
  // ==========================================================
  // tasks
  task automatic conclude();
    $display("compares %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    tests_run++;
    if (s !== e)
    begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [15:0] v);
    logic pa, pw;
    pa = 1; pw = 1;
    @(posedge clk);
    awa <= a; wd <= {16'h0000, v}; awv <= 1; wv <= 1; br <= 1;
    while (pa || pw)
    begin
      @(posedge clk);
      if (pa && awr) begin pa = 0; awv <= 0; end
      if (pw && wrdy) begin pw = 0; wv <= 0; end
    end
    do begin @(posedge clk); end while (!bv);
    br <= 0;
    chk("bresp", RESP_OKAY, bresp);
    @(posedge clk);
  endtask : wr
  task automatic rd(logic [7:0] a, logic [31:0] e, logic [1:0] er);
    @(posedge clk);
    ara <= a; arv <= 1; rr <= 1;
    do begin @(posedge clk); end while (!arr);
    arv <= 0;
    do begin @(posedge clk); end while (!rv);
    rr <= 0;
    chk("rresp", er, rresp);
    if (er == RESP_OKAY) chk("rdata", e, rdat);
    @(posedge clk);
  endtask : rd
  // spacing between pulses once the new setting is in use
  task automatic per(int i, int e);
    int n;
    for (int j = 0; j < 3; j++)
    begin
      n = 0;
      do begin @(negedge clk); n++; end while (!sig[i] && n < 5000);
    end
    chk("period", e, n);
  endtask : per
  // random source ticks against a counting model of the core gate
  task automatic rnd(int m);
    int s, c, b;
    s = 0; c = 0;
    mp <= 1;
    repeat (2) @(posedge clk);
    mp <= 0;
    repeat (5) @(posedge clk);
    for (int k = 0; k < 200; k++)
    begin
      @(posedge clk);
      c += core;
      b = k < 189 ? $random(seed) & 1 : (k == 189 ? s % 2 : 0);
      mp <= b[0];
      s += b;
    end
    chk("core count", m == 1 ? s : (m == 2 ? s / 2 : 0), c);
  endtask : rnd
  // ==========================================================
  // scenarios
  initial
  begin
    repeat (20) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    rd(8'h30, RST_CLOCK_DIVIDER, RESP_OKAY);
    rd(8'h34, 32'h38, RESP_OKAY);
    rd(8'h38, 0, RESP_OKAY);
    rd(8'h08, 0, RESP_SLVERR);
    wr(8'h38, 16'hFFFF);
    rd(8'h38, MSK_SOURCE_ENABLE, RESP_OKAY);
    for (int m = 0; m < 4; m++)
    begin
      wr(8'h38, 16'h0000);
      wr(8'h30, m == 2 ? 16'h0080 : 16'h0000);
      wr(8'h38, m == 0 ? 16'h0000 : (m == 3 ? 16'h2001 : 16'h0001));
      rnd(m);
    end
    wr(8'h38, 16'h0000);
    wr(8'h30, 16'h0000);
    mp <= 1;
    wr(8'h38, 16'h0027);
    per(1, 1);
    for (int c = 0; c < 3; c++)
    begin
      wr(8'h34, 16'(c * 16 + 8));
      per(2, rt[c]);
    end
    for (int s = 0; s < 4; s++)
    begin
      wr(8'h30, 16'(s * 256));
      per(3, 8 >> s);
    end
    wr(8'h34, 16'h003B);
    repeat (300) @(negedge clk);
    begin
      int c;
      c = 0;
      repeat (600) begin @(negedge clk); c += fs; end
      chk("reserved fs", 0, c);
    end
    chk("pin oe", 1, oe);
    wr(8'h38, 16'h0000);
    lp <= 1;
    wr(8'h38, 16'h2021);
    for (int k = 0; k < 8; k++)
    begin
      wr(8'h30, 16'(k * 1024));
      per(4, od[k]);
    end
    chk("pin oe", 0, oe);
    wr(8'h38, 16'h2001);
    repeat (4) @(negedge clk);
    chk("pin oe", 1, oe);
    wr(8'h40, 16'h0018);
    chk("loop ref", 1, lr);
    chk("loop hold", 1, lh);
    wr(8'h5C, 16'h0003);
    wr(8'h60, 16'h0004);
    per(5, 4);
    per(6, 256);
    wr(8'h5C, 16'h0007);
    eb <= 1;
    per(6, 64);
    conclude();
  end
endmodule : acc_clock_control_tb
